//--- rpt_filter.sv
// Glitch filter with active level selection and edge pulses for one input
`timescale 1ns/100ps
module rpt_filter #(
   parameter int W = rpt_pkg::GLITCH_W
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic ce,
   input wire logic pin,
   input wire logic act_high,
   input wire logic [W-1:0] glitch_cyc,
   output logic level,
   output logic rise,
   output logic fall
);
   import rpt_pkg::*;

   typedef struct packed {
      logic s1;
      logic s2;
      logic lvl;
      logic rise;
      logic fall;
      logic [W-1:0] cnt;
   } rpt_flt_t;

   rpt_flt_t r;
   rpt_flt_t next_r;
   logic on_now;

   // ==========================================
   // Filter: a new level counts only after holding for the glitch time
   always_comb begin
      next_r = r;
      next_r.s1 = pin;
      next_r.s2 = r.s1;
      next_r.rise = 1'b0;
      next_r.fall = 1'b0;
      on_now = (r.s2 == act_high);
      if (on_now == r.lvl) begin
         next_r.cnt = '0;
      end else if (r.cnt + 1'b1 >= glitch_cyc) begin
         next_r.cnt = '0;
         next_r.lvl = on_now;
         next_r.rise = on_now;
         next_r.fall = ~on_now;
      end else begin
         next_r.cnt = r.cnt + 1'b1;
      end
   end

   // State register
   always_ff @(posedge clk) begin
      if (srst) begin
         r <= '0;
      end else if (ce) begin
         r <= next_r;
      end
   end

   assign level = r.lvl;
   assign rise = r.rise;
   assign fall = r.fall;
endmodule : rpt_filter

//--- rpt_pkg.sv
// Package of constants and types for the reading phase trigger block
package rpt_pkg;
   // ==========================================
   // Timing
   localparam int CLK_HZ = 50000000;
   localparam int GLITCH_US = 500;
   localparam int GLITCH_CYC = (GLITCH_US * (CLK_HZ / 1000000));
   localparam int GLITCH_W = 24;
   localparam int TMO_W = 24;
   localparam int TMO_CYC_DEF = 50000;
   // ==========================================
   // Sensor arrangements
   typedef enum logic [1:0] {
      RPT_SINGLE,
      RPT_DUAL,
      RPT_CTRL,
      RPT_HOST
   } rpt_arr_t;
   // ==========================================
   // Output event selectors
   typedef enum logic [2:0] {
      RPT_EV_NONE,
      RPT_EV_PHASE_ON,
      RPT_EV_PHASE_OFF,
      RPT_EV_FAIL,
      RPT_EV_COMPLETE
   } rpt_ev_t;
   // Output mode field position and output reset value
   localparam int OM_TMO_EN = 0;
   localparam logic [1:0] OUT_RST = 2'h0;
endpackage : rpt_pkg

//--- rpt_sensor.sv
// Presence sensor model driving the two raw inputs
`timescale 1ns/100ps
module rpt_sensor (
   output logic trig_pin,
   output logic in2_pin
);
   // Both sensors start with no object seen
   initial begin
      trig_pin = 1'b0;
      in2_pin = 1'b0;
   end
   // Clean switching of both sensor outputs
   task put(input logic t, input logic i);
      trig_pin = t;
      in2_pin = i;
   endtask : put
endmodule : rpt_sensor

//--- rpt_top.sv
// Reading phase control from two filtered inputs and two result outputs
`timescale 1ns/100ps
//
// Contract
// - Single sensor: trigger on starts, off stops
// - Two sensors: trigger on starts, input two stops
// - Controller: either on starts, either off stops
// - Host commands may start and stop phase
// - Each input has selectable active level
// - Pulses under half millisecond are ignored
// - Glitch time can be raised above default
// - Trigger lamp follows filtered active trigger
// - Output one defaults to failed read
// - Output two defaults to complete read
// - Outputs follow activation, deactivation, timeout events
// - Host may force each output independently
// - Menu in use: offline, no phases, no data
module rpt_top #(
   parameter int GW = rpt_pkg::GLITCH_W,
   parameter int TW = rpt_pkg::TMO_W
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic ce,
   input wire logic trig_pin,
   input wire logic in2_pin,
   input wire rpt_pkg::rpt_arr_t arrangement,
   input wire logic trig_act_high,
   input wire logic in2_act_high,
   input wire logic [GW-1:0] glitch_cyc,
   input wire logic host_start,
   input wire logic host_stop,
   input wire logic menu_active,
   input wire logic result_valid,
   input wire logic result_complete,
   input wire logic result_data_req,
   input wire rpt_pkg::rpt_ev_t out1_on_ev,
   input wire rpt_pkg::rpt_ev_t out1_off_ev,
   input wire rpt_pkg::rpt_ev_t out2_on_ev,
   input wire rpt_pkg::rpt_ev_t out2_off_ev,
   input wire logic [1:0] out_tmo_en,
   input wire logic [TW-1:0] out_tmo_cyc,
   input wire logic [1:0] host_out_force,
   input wire logic [1:0] host_out_value,
   output logic phase_active,
   output logic phase_start,
   output logic phase_end,
   output logic trig_lamp,
   output logic result_data_en,
   output logic offline,
   output logic [1:0] out_pin
);
   import rpt_pkg::*;

   // ==========================================
   // State
   typedef struct packed {
      logic phase;
      logic start;
      logic stop;
      logic lamp;
      logic data_en;
      logic offl;
      logic [1:0] outp;
      logic [1:0] evout;
      logic [TW-1:0] t0;
      logic [TW-1:0] t1;
   } rpt_st_t;

   rpt_st_t r;
   rpt_st_t next_r;

   logic t_lvl;
   logic t_rise;
   logic t_fall;
   logic i_lvl;
   logic i_rise;
   logic i_fall;
   logic go;
   logic halt;
   logic [7:0] ev; // Spare selector codes read as no event
   logic [2:0] on_sel [2];
   logic [2:0] off_sel [2];

   // ==========================================
   // Input filters, each with two sync stages inside
   rpt_filter #(.W(GW)) u_trig (
      .clk(clk),
      .srst(srst),
      .ce(ce),
      .pin(trig_pin),
      .act_high(trig_act_high),
      .glitch_cyc(glitch_cyc),
      .level(t_lvl),
      .rise(t_rise),
      .fall(t_fall)
   );

   rpt_filter #(.W(GW)) u_in2 (
      .clk(clk),
      .srst(srst),
      .ce(ce),
      .pin(in2_pin),
      .act_high(in2_act_high),
      .glitch_cyc(glitch_cyc),
      .level(i_lvl),
      .rise(i_rise),
      .fall(i_fall)
   );

   // Event selectors as plain codes per output
   assign on_sel[0] = out1_on_ev;
   assign on_sel[1] = out2_on_ev;
   assign off_sel[0] = out1_off_ev;
   assign off_sel[1] = out2_off_ev;

   // ==========================================
   // Start and stop decision per arrangement
   always_comb begin
      go = 1'b0;
      halt = 1'b0;
      unique case (arrangement)
         RPT_SINGLE: begin
            go = t_rise;
            halt = t_fall;
         end
         RPT_DUAL: begin
            go = t_rise;
            halt = i_rise;
         end
         RPT_CTRL: begin
            go = t_rise | i_rise;
            halt = t_fall | i_fall;
         end
         RPT_HOST: begin
            go = host_start;
            halt = host_stop;
         end
      endcase
   end

   // Event vector indexed by rpt_ev_t codes
   always_comb begin
      ev = '0;
      ev[RPT_EV_PHASE_ON] = r.start;
      ev[RPT_EV_PHASE_OFF] = r.stop;
      ev[RPT_EV_FAIL] = result_valid & ~result_complete;
      ev[RPT_EV_COMPLETE] = result_valid & result_complete;
   end

   // ==========================================
   // Phase, lamp, offline and output sequencing
   always_comb begin
      logic [TW-1:0] tn;
      logic on_hit;
      logic off_hit;
      logic was;
      tn = '0;
      on_hit = 1'b0;
      off_hit = 1'b0;
      was = 1'b0;
      next_r = r;
      next_r.start = 1'b0;
      next_r.stop = 1'b0;
      next_r.lamp = t_lvl;
      next_r.offl = menu_active;
      if (menu_active) begin
         if (r.phase) begin
            next_r.stop = 1'b1;
         end
         next_r.phase = 1'b0;
      end else if (!r.phase && go) begin
         next_r.phase = 1'b1;
         next_r.start = 1'b1;
      end else if (r.phase && halt) begin
         next_r.phase = 1'b0;
         next_r.stop = 1'b1;
      end
      // No result data leaves while offline
      next_r.data_en = result_data_req & ~menu_active;
      for (int k = 0; k < 2; k++) begin
         on_hit = (on_sel[k] != RPT_EV_NONE) && ev[on_sel[k]];
         off_hit = (off_sel[k] != RPT_EV_NONE) && ev[off_sel[k]];
         tn = (k == 0) ? r.t0 : r.t1;
         was = r.evout[k];
         if (!was && on_hit) begin
            next_r.evout[k] = 1'b1;
            tn = out_tmo_cyc;
         end else if (was && off_hit) begin
            next_r.evout[k] = 1'b0;
            tn = '0;
         end else if (was && out_tmo_en[k]) begin
            if (tn <= 1) begin
               next_r.evout[k] = 1'b0;
               tn = '0;
            end else begin
               tn = tn - 1'b1;
            end
         end
         if (k == 0) begin
            next_r.t0 = tn;
         end else begin
            next_r.t1 = tn;
         end
         // Host force overrides event result
         next_r.outp[k] = host_out_force[k] ? host_out_value[k]
                                            : next_r.evout[k];
      end
   end

   // State register
   always_ff @(posedge clk) begin
      if (srst) begin
         r <= '0;
         r.outp <= OUT_RST;
      end else if (ce) begin
         r <= next_r;
      end
   end

   assign phase_active = r.phase;
   assign phase_start = r.start;
   assign phase_end = r.stop;
   assign trig_lamp = r.lamp;
   assign result_data_en = r.data_en;
   assign offline = r.offl;
   assign out_pin = r.outp;
endmodule : rpt_top

//--- rpt_top_monitor.sv
// Checker of phase and output behaviour at the top ports
`timescale 1ns/100ps
module rpt_top_monitor
   import rpt_pkg::*;
(
   input wire logic clk,
   input wire logic srst,
   input wire logic ce,
   input wire rpt_pkg::rpt_arr_t arrangement,
   input wire logic host_start,
   input wire logic host_stop,
   input wire logic menu_active,
   input wire logic result_valid,
   input wire logic result_complete,
   input wire rpt_pkg::rpt_ev_t out1_on_ev,
   input wire rpt_pkg::rpt_ev_t out1_off_ev,
   input wire logic [1:0] host_out_force,
   input wire logic [1:0] host_out_value,
   input wire logic phase_active,
   input wire logic phase_start,
   input wire logic phase_end,
   input wire logic result_data_en,
   input wire logic offline,
   input wire logic [1:0] out_pin
);
   // ==========================================
   // Phase and output relations
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   chk_start_pulse:
   assert property (phase_start && ce |=> !phase_start)
      else $error("Start pulse too long");
   chk_start_sets:
   assert property (phase_start |-> phase_active)
      else $error("Start without phase");
   chk_host_start:
   assert property (arrangement == RPT_HOST && host_start && !host_stop &&
      !phase_active && !menu_active && ce |=> phase_start)
      else $error("Host start missed");
   chk_host_stop:
   assert property (arrangement == RPT_HOST && host_stop && phase_active &&
      ce |=> phase_end && !phase_active)
      else $error("Host stop missed");
   chk_menu_block:
   assert property (menu_active && ce |=> !phase_start)
      else $error("Start while offline");
   chk_menu_quiet:
   assert property (menu_active && ce |=> offline && !result_data_en)
      else $error("Offline not kept");
   chk_host_force:
   assert property (host_out_force[0] && ce |=> out_pin[0] ==
      $past(host_out_value[0]))
      else $error("Forced output wrong");
   chk_fail_out:
   assert property (result_valid && !result_complete && ce &&
      out1_on_ev == RPT_EV_FAIL && out1_off_ev != RPT_EV_FAIL &&
      !host_out_force[0] |=> out_pin[0])
      else $error("Fail output not set");
endmodule : rpt_top_monitor
bind rpt_top rpt_top_monitor u_rpt_top_monitor (.*);

//--- rpt_top_tb.sv
// Self-checking bench for the reading phase trigger block
`timescale 1ns/100ps
module rpt_top_tb;
   import rpt_pkg::*;
   logic clk = 0, srst = 1, hs = 0, hp = 0, menu = 0, rv = 0, rc = 0;
   logic rq = 0, iah = 1, h, t_pin, i_pin, pa, ps, pe, lamp, rde, off;
   logic tah = 1;
   logic [1:0] f = 2'h0, v = 2'h0, te = 2'h2, pins;
   logic [23:0] gc = 24'h4;
   rpt_arr_t arr = RPT_SINGLE;
   rpt_ev_t e1n = RPT_EV_FAIL, e1f = RPT_EV_PHASE_ON;
   rpt_ev_t e2n = RPT_EV_COMPLETE, e2f = RPT_EV_PHASE_ON;
   int failures = 0, compares = 0;
   // ==========================================
   // Clock, partner and design
   always #10 clk = ~clk;
   rpt_sensor u_rpt_sensor (.trig_pin(t_pin), .in2_pin(i_pin));
   rpt_top u_rpt_top (.clk(clk), .srst(srst), .ce(1'b1), .trig_pin(t_pin),
      .in2_pin(i_pin), .arrangement(arr), .trig_act_high(tah),
      .in2_act_high(iah), .glitch_cyc(gc), .host_start(hs), .host_stop(hp),
      .menu_active(menu), .result_valid(rv), .result_complete(rc),
      .result_data_req(rq), .out1_on_ev(e1n), .out1_off_ev(e1f),
      .out2_on_ev(e2n), .out2_off_ev(e2f), .out_tmo_en(te),
      .out_tmo_cyc(24'hA), .host_out_force(f), .host_out_value(v),
      .phase_active(pa), .phase_start(ps), .phase_end(pe), .trig_lamp(lamp),
      .result_data_en(rde), .offline(off), .out_pin(pins));
   // ==========================================
   // Shared helpers
   task go(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : go
   task chk(input string s, input logic [1:0] e, input logic [1:0] g);
      compares++;
      if (e !== g) begin
         failures++;
         $display("Error %s expected %h seen %h", s, e, g);
      end
   endtask : chk
   // Bounded wait for a start or end pulse
   task wt(input logic sel, output logic hit);
      hit = 0;
      for (int k = 0; k < 20 && !hit; k++) begin
         go(1);
         hit = sel ? pe : ps;
      end
   endtask : wt
   task stop_test;
      $display("Checks %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : stop_test
   // ==========================================
   // Scenarios
   task t_glitch(input int g);
      gc = g[23:0];
      u_rpt_sensor.put(1, 0);
      go(g - 1);
      u_rpt_sensor.put(0, 0);
      wt(0, h);
      chk("glitch", 0, h);
   endtask : t_glitch
   task t_single;
      u_rpt_sensor.put(1, 0);
      wt(0, h);
      chk("start", 1, h);
      go(1);
      chk("lamp", 1, lamp);
      u_rpt_sensor.put(0, 0);
      wt(1, h);
      chk("end", 1, h);
   endtask : t_single
   task t_dual;
      arr = RPT_DUAL;
      u_rpt_sensor.put(0, 1);
      iah = 0;
      go(20);
      u_rpt_sensor.put(1, 1);
      wt(0, h);
      chk("dual start", 1, h);
      u_rpt_sensor.put(0, 1);
      wt(1, h);
      chk("trig off", 0, h);
      u_rpt_sensor.put(0, 0);
      wt(1, h);
      chk("dual end", 1, h);
   endtask : t_dual
   task t_ctrl;
      arr = RPT_CTRL;
      u_rpt_sensor.put(0, 1);
      go(20);
      u_rpt_sensor.put(0, 0);
      wt(0, h);
      chk("ctrl start", 1, h);
      u_rpt_sensor.put(0, 1);
      wt(1, h);
      chk("ctrl end", 1, h);
      // Low trigger pin now counts as on
      tah = 0;
      wt(0, h);
      chk("low trig start", 1, h);
      u_rpt_sensor.put(1, 1);
      wt(1, h);
      chk("trig end", 1, h);
   endtask : t_ctrl
   task t_host;
      arr = RPT_HOST;
      hs = 1;
      go(1);
      hs = 0;
      chk("host start", 1, ps);
      hp = 1;
      go(1);
      hp = 0;
      chk("host stop", 1, pe);
   endtask : t_host
   task t_menu;
      menu = 1;
      rq = 1;
      hs = 1;
      go(1);
      hs = 0;
      go(1);
      chk("offline", 1, off);
      chk("no phase", 0, pa);
      chk("no data", 0, rde);
      menu = 0;
      go(2);
      chk("data", 1, rde);
      rq = 0;
   endtask : t_menu
   task t_out;
      rv = 1;
      go(1);
      rv = 0;
      chk("fail", 2'h1, pins);
      rv = 1;
      rc = 1;
      go(1);
      rv = 0;
      rc = 0;
      chk("complete", 2'h3, pins);
      go(8);
      chk("hold", 2'h3, pins);
      go(3);
      chk("timeout", 2'h1, pins);
      hs = 1;
      go(1);
      hs = 0;
      go(2);
      chk("event off", 2'h0, pins);
      f = 2'h3;
      v = 2'h2;
      go(1);
      chk("force", 2'h2, pins);
      f = 2'h0;
      e2n = RPT_EV_PHASE_OFF;
      hp = 1;
      go(1);
      hp = 0;
      chk("release", 2'h0, pins);
      go(1);
      chk("phase off event", 2'h2, pins);
   endtask : t_out
   // ==========================================
   // Main sequence
   initial begin
      go(2);
      srst = 0;
      t_glitch(8);
      t_glitch(4);
      t_single();
      t_dual();
      t_ctrl();
      t_host();
      t_menu();
      t_out();
      stop_test();
   end
endmodule : rpt_top_tb
